//--- include/svr_pkg.sv
// package: constants and carrier types for the supervisor watchdog reset block
package svr_pkg;
  localparam int unsigned CLK_FREQ_HZ     = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  // minimum reset width in msec
  localparam int unsigned RESET_MIN_MS    = 500;
  // typical watchdog time-out in msec
  localparam int unsigned WDOG_TYP_MS     = 700;
  // minimum strobe width in nsec
  localparam int unsigned STROBE_MIN_NS   = 500;
  // debounce settle time in msec
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned RESET_MIN_CYC   = RESET_MIN_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned WDOG_CYC        = WDOG_TYP_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_FREQ_HZ / 1000);
  // strobe must be seen this long; rounded down so a legal strobe is never missed
  localparam int unsigned STROBE_CYC_RAW  = STROBE_MIN_NS / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC      = (STROBE_CYC_RAW > 2) ? STROBE_CYC_RAW - 2 : 1;
  localparam int unsigned CNT_W           = 26;

  typedef enum logic [1:0] {
    SVR_POWER  = 2'b00,
    SVR_HOLD   = 2'b01,
    SVR_RUN    = 2'b10,
    SVR_MANUAL = 2'b11
  } svr_state_t;

  // line level as seen by the comparators of the pin
  typedef struct packed {
    logic fullLow;    // below the push switch low level
    logic strobeLow;  // at or below the strobe low level
  } svr_line_t;
endpackage

//--- rtl/svr_debounce.sv
// level debouncer: output follows input only after it stays stable for a set time
`timescale 1ns/1ps
`default_nettype none
module svr_debounce
  import svr_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstN,
  // level in and filtered level out
  input  wire logic rawIn,
  output logic      cleanOut
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_cleanOut;

  always_comb begin
    next_count    = '0;
    next_cleanOut = cleanOut;
    if (rawIn != cleanOut) begin
      if (count >= CNT_W'(STABLE_CYC - 1)) begin
        next_cleanOut = rawIn;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count    <= '0;
      cleanOut <= 1'b0;
    end else begin
      count    <= next_count;
      cleanOut <= next_cleanOut;
    end
  end
endmodule
`default_nettype wire

//--- rtl/svr_supervisor.sv
// supervisor: power reset, watchdog and manual override on one open-drain pin
// Functional notes
// - the line is pulled low on the third clock edge (two sync flops plus the registered drive) whenever the supply monitor reports low supply.
// - after the supply recovers the line stays low for at least 500 msec.
// - a strobe-low level seen while reset is not driven restarts the watchdog count.
// - a watchdog expiry drives a reset pulse of at least 500 msec.
// - without strobes a new reset pulse follows every further time-out until a strobe.
// - the watchdog time-out is 700 msec from the last strobe or from reset release.
// - the pin is open-drain and only ever pulls the line low.
// - an external low request is debounced into one reset event.
// - an external override stretches reset to at least 500 msec.
`timescale 1ns/1ps
`default_nettype none
module svr_supervisor
  import svr_pkg::*;
#(
  parameter int unsigned RESET_CYC  = RESET_MIN_CYC,
  parameter int unsigned WDOG_TO    = WDOG_CYC,
  parameter int unsigned DEB_CYC    = DEBOUNCE_CYC,
  parameter int unsigned STROBE_LEN = STROBE_CYC
) (
  // clock and reset
  input  wire logic      clk,
  input  wire logic      reset_n,
  // supply monitor, high while supply is within tolerance
  input  wire logic      supplyOk,
  // reset_strobe_pin comparator levels
  input  wire svr_line_t lineIn,
  // reset_strobe_pin open-drain drive
  output logic           pinOut,
  output logic           pinOe,
  // status
  output logic           resetActive,
  output logic           wdogExpired
);
  logic       rstMeta;
  logic       rstN;
  logic [2:0] metaQ;
  logic [2:0] syncQ;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // pins are asynchronous; two flops before use
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      metaQ <= 3'h0;
      syncQ <= 3'h0;
    end else begin
      metaQ <= {supplyOk, lineIn.fullLow, lineIn.strobeLow};
      syncQ <= metaQ;
    end
  end

  logic supOk;
  logic fullLowS;
  logic strobeLowS;
  assign supOk      = syncQ[2];
  assign fullLowS   = syncQ[1];
  assign strobeLowS = syncQ[0];

  logic manualReq;
  // runs always; its edge only counts in run, so the own pull never reads as manual
  svr_debounce #(
    .STABLE_CYC(DEB_CYC)
  ) u_debounce (
    .clk     (clk),
    .rstN    (rstN),
    .rawIn   (fullLowS),
    .cleanOut(manualReq)
  );

  svr_state_t       state;
  svr_state_t       next_state;
  logic [CNT_W-1:0] holdCnt;
  logic [CNT_W-1:0] next_holdCnt;
  logic [CNT_W-1:0] wdCnt;
  logic [CNT_W-1:0] next_wdCnt;
  logic [CNT_W-1:0] stbCnt;
  logic [CNT_W-1:0] next_stbCnt;
  logic             next_pinOe;
  logic             next_wdogExpired;
  logic             strobeSeen;
  logic             manualPrev;
  logic             manualEdge;

  // full low is a manual pull, never a strobe
  assign strobeSeen = strobeLowS && !fullLowS && (stbCnt >= CNT_W'(STROBE_LEN));
  assign manualEdge = manualReq && !manualPrev;

  always_comb begin
    next_state       = state;
    next_holdCnt     = holdCnt;
    next_wdCnt       = wdCnt;
    // saturates at the qualify length so a long strobe never wraps into a miss
    next_stbCnt      = '0;
    if (strobeLowS && !fullLowS) begin
      next_stbCnt = (stbCnt < CNT_W'(STROBE_LEN)) ? stbCnt + CNT_W'(1) : stbCnt;
    end
    next_wdogExpired = 1'b0;
    unique case (state)
      SVR_POWER: begin
        next_holdCnt = '0;
        if (supOk) begin
          next_state = SVR_HOLD;
        end
      end
      SVR_HOLD, SVR_MANUAL: begin
        next_wdCnt  = '0;
        next_stbCnt = '0;
        // own pull hides the switch, so the stretch runs from the manual event
        if (holdCnt >= CNT_W'(RESET_CYC - 1)) begin
          next_state   = SVR_RUN;
          next_holdCnt = '0;
        end else begin
          next_holdCnt = holdCnt + CNT_W'(1);
        end
      end
      SVR_RUN: begin
        next_holdCnt = '0;
        if (manualEdge) begin
          next_state = SVR_MANUAL;
        end else if (strobeSeen) begin
          next_wdCnt = '0;
        end else if (wdCnt >= CNT_W'(WDOG_TO - 1)) begin
          next_state       = SVR_HOLD;
          next_wdogExpired = 1'b1;
          next_wdCnt       = '0;
        end else begin
          next_wdCnt = wdCnt + CNT_W'(1);
        end
      end
    endcase
    if (!supOk) begin
      next_state   = SVR_POWER;
      next_holdCnt = '0;
      next_wdCnt   = '0;
    end
    next_pinOe = (next_state != SVR_RUN);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state       <= SVR_POWER;
      holdCnt     <= '0;
      wdCnt       <= '0;
      stbCnt      <= '0;
      pinOe       <= 1'b1;
      pinOut      <= 1'b0;
      resetActive <= 1'b1;
      wdogExpired <= 1'b0;
      manualPrev  <= 1'b0;
    end else begin
      state       <= next_state;
      holdCnt     <= next_holdCnt;
      wdCnt       <= next_wdCnt;
      stbCnt      <= next_stbCnt;
      pinOe       <= next_pinOe;
      pinOut      <= 1'b0;
      resetActive <= next_pinOe;
      wdogExpired <= next_wdogExpired;
      manualPrev  <= manualReq;
    end
  end

  sequence s_expiry;
    state == SVR_RUN && wdCnt >= CNT_W'(WDOG_TO - 1) && !strobeSeen && !manualEdge && supOk;
  endsequence

  sequence s_released;
    $fell(pinOe);
  endsequence

  sequence s_manual_seen;
    state == SVR_RUN && manualEdge && supOk;
  endsequence

  a_supply_low_pull: assert property (@(posedge clk) disable iff (!rstN)
    !supOk |=> pinOe) else $error("line not pulled during low supply");
  a_recover_hold_min: assert property (@(posedge clk) disable iff (!rstN)
    (state == SVR_POWER && supOk) |=> pinOe [*8]) else $error("power reset too short");
  a_strobe_restart: assert property (@(posedge clk) disable iff (!rstN)
    (state == SVR_RUN && strobeSeen && !manualEdge && supOk) |=> wdCnt == '0)
    else $error("strobe did not restart watchdog");
  a_expiry_pulse: assert property (@(posedge clk) disable iff (!rstN)
    s_expiry |=> wdogExpired ##0 pinOe [*4]) else $error("expiry gave no reset pulse");
  a_hold_length: assert property (@(posedge clk) disable iff (!rstN)
    s_released |-> $past(holdCnt) >= CNT_W'(RESET_CYC - 1))
    else $error("reset released early");
  a_count_rises: assert property (@(posedge clk) disable iff (!rstN)
    (state == SVR_RUN && !strobeSeen && !manualEdge && supOk && wdCnt < CNT_W'(WDOG_TO - 1))
    |=> wdCnt == $past(wdCnt) + CNT_W'(1)) else $error("watchdog count stalled");
  a_open_drain: assert property (@(posedge clk) disable iff (!rstN)
    !pinOut) else $error("pin driven high");
  a_ignore_in_reset: assert property (@(posedge clk) disable iff (!rstN)
    (state == SVR_HOLD || state == SVR_MANUAL) |=> wdCnt == '0)
    else $error("count moved during reset");
  a_manual_stretch: assert property (@(posedge clk) disable iff (!rstN)
    s_manual_seen |=> pinOe [*6]) else $error("manual not stretched");
  a_strobe_level: assert property (@(posedge clk) disable iff (!rstN)
    fullLowS |-> !strobeSeen) else $error("full low taken as strobe");
  a_status_copy: assert property (@(posedge clk) disable iff (!rstN)
    resetActive == pinOe) else $error("status differs from line drive");
  a_expiry_single: assert property (@(posedge clk) disable iff (!rstN)
    wdogExpired |=> !wdogExpired) else $error("expiry flag longer than one cycle");
  a_strobe_cleared: assert property (@(posedge clk) disable iff (!rstN)
    (state == SVR_HOLD || state == SVR_MANUAL) |=> stbCnt == '0)
    else $error("strobe qualify ran during reset");
  a_manual_debounced: assert property (@(posedge clk) disable iff (!rstN)
    manualEdge |-> $past(fullLowS) && $past(fullLowS, 2))
    else $error("manual edge not debounced");
endmodule
`default_nettype wire

//--- tb/svr_host_model.sv
// host processor and push switch side of the reset/strobe line
`timescale 1ns/1ps
`default_nettype none
module svr_host_model
  import svr_pkg::*;
(
  // device drive
  input  wire logic      pinOe,
  // host strobe and switch requests
  input  wire logic      strobeReq,
  input  wire logic      pushReq,
  // comparator levels seen by the device
  output wire svr_line_t lineIn
);
  // wired-or line: device or switch pulls full low, divider strobe stays above it
  logic fullPull;
  assign fullPull         = pinOe | pushReq;
  assign lineIn.fullLow   = fullPull;
  assign lineIn.strobeLow = fullPull | strobeReq;
endmodule
`default_nettype wire

//--- tb/svr_supervisor_tb.sv
// self-checking bench for the supervisor watchdog reset block
`timescale 1ns/1ps
`default_nettype none
module svr_supervisor_tb;
  import svr_pkg::*;
  localparam int RC = 50;
  localparam int WT = 100;
  logic      clk, reset_n, supplyOk, strobeReq, pushReq;
  logic      pinOut, pinOe, resetActive, wdogExpired;
  svr_line_t lineIn;
  int        errors, cmp_count, rises, pulses, n;
  svr_supervisor #(.RESET_CYC(RC), .WDOG_TO(WT), .DEB_CYC(5), .STROBE_LEN(2)) DUT (
    .clk(clk), .reset_n(reset_n), .supplyOk(supplyOk), .lineIn(lineIn), .pinOut(pinOut),
    .pinOe(pinOe), .resetActive(resetActive), .wdogExpired(wdogExpired));
  svr_host_model host (.pinOe(pinOe), .strobeReq(strobeReq), .pushReq(pushReq),
    .lineIn(lineIn));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge pinOe) rises++;
  always @(posedge wdogExpired) pulses++;
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // bounded wait for the drive to reach a level, returns cycles taken
  task automatic waitOe(input logic v, output int c);
    c = 0;
    while (pinOe !== v) begin
      tick(1);
      c++;
      if (c > 2000) begin
        errors++;
        $display("[ERR] %0t got %h exp %h", $time, pinOe, v);
        summarize();
      end
    end
  endtask
  // strobe held past the qualify length plus sync delay
  task automatic strobe();
    strobeReq = 1'b1;
    tick(6);
    strobeReq = 1'b0;
    tick(1);
  endtask
  task automatic t_power();
    tick(10);
    chk(pinOe, 1);
    chk(resetActive, 1);
    chk(pinOut, 0);
    supplyOk = 1'b1;
    waitOe(0, n);
    chk(n >= RC && n <= RC + 8, 1);
    chk(resetActive, 0);
    $display("power-up test done");
  endtask
  task automatic t_strobe();
    rises = 0;
    repeat (5) begin
      tick(WT - 20);
      strobe();
    end
    chk(rises, 0);
    $display("strobe test done");
  endtask
  task automatic t_expire();
    rises = 0;
    pulses = 0;
    waitOe(1, n);
    chk(n >= WT - 10 && n <= WT + 5, 1);
    chk(pulses, 1);
    strobe();
    waitOe(0, n);
    chk(n >= RC - 7, 1);
    waitOe(1, n);
    chk(n >= WT - 2 && n <= WT + 5, 1);
    chk(pulses, 2);
    waitOe(0, n);
    tick(WT / 2);
    strobe();
    tick(WT - 20);
    chk(pinOe, 0);
    $display("expiry test done");
  endtask
  task automatic t_push();
    rises = 0;
    strobe();
    repeat (3) begin
      pushReq = 1'b1;
      tick(2);
      pushReq = 1'b0;
      tick(2);
    end
    pushReq = 1'b1;
    waitOe(1, n);
    chk(n >= 6 && n <= 10, 1);
    pushReq = 1'b0;
    waitOe(0, n);
    chk(n >= RC, 1);
    chk(rises, 1);
    tick(WT - 40);
    pushReq = 1'b1;
    tick(3);
    pushReq = 1'b0;
    waitOe(1, n);
    chk(n >= 30 && n < 50, 1);
    waitOe(0, n);
    $display("push test done");
  endtask
  task automatic t_supply();
    tick(10);
    supplyOk = 1'b0;
    waitOe(1, n);
    chk(n <= 4, 1);
    tick(2 * RC);
    chk(pinOe, 1);
    supplyOk = 1'b1;
    waitOe(0, n);
    chk(n >= RC, 1);
    $display("supply test done");
  endtask
  initial begin
    reset_n = 1'b0;
    supplyOk = 1'b0;
    strobeReq = 1'b0;
    pushReq = 1'b0;
    errors = 0;
    cmp_count = 0;
    tick(3);
    reset_n = 1'b1;
    t_power();
    t_strobe();
    t_expire();
    t_push();
    t_supply();
    summarize();
  end
endmodule
`default_nettype wire
